// [logic/plrd_ctrl.sv]
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Range writes ignored while loop on
// - Zero range disables loop, clears select
// - Select cannot set with zero range
// - Range resets to 64
// - Divider writes ignored while loop on
// - Divider zero acts as one
// - Divider resets to one
// - Divider upper nibble reads zero
// - Auto mode lock change sets flag
// - Flag sets regardless of enable
// - Manual mode: no interrupt, flag reads zero
// - Select accepted even while unlocked
// - Wait leaves everything unchanged
// - Stop without oscillator option: clock, enable and interrupt outputs low
// - Stop clears base clock select
// - Stop with option keeps oscillator
// - Break with clear enable: reads clear
// - Break without clear enable: flag kept
// - Loop control read clears flag
// - Base clock is half selected source
// - Interrupt only when enable set
module plrd_ctrl (
   input wire logic REF_CLK, // System clock, 250 MHz
   input wire logic RST_N, // Asynchronous reset, active low
   input wire logic PSEL, // APB select
   input wire logic PENABLE, // APB access phase
   input wire logic PWRITE, // APB direction
   input wire logic [7:0] PADDR, // APB byte address
   input wire logic [31:0] PWDATA, // APB write data
   output logic [31:0] PRDATA, // APB read data
   output logic PREADY, // APB ready
   output logic PSLVERR, // APB error on unmapped address
   input wire logic LOCK_IN, // Lock indicator from analog loop
   input wire logic XTAL_CLK_IN, // Crystal clock level, sampled
   input wire logic VCO_CLK_IN, // VCO clock level, sampled
   input wire logic WAIT_IN, // Wait low-power state
   input wire logic STOP_IN, // Stop low-power state
   input wire logic OSC_STOP_EN, // Oscillator runs in stop
   input wire logic BREAK_IN, // Debug break active
   input wire logic BREAK_CLR_EN, // Break clear enable
   output logic LOOP_ENABLE, // Loop power on to analog
   output logic OSC_ENABLE, // Oscillator enable
   output logic [7:0] RANGE_OUT, // Range multiplier to VCO
   output logic [3:0] REF_DIV_OUT, // Effective reference divider
   output logic XTAL_CLK_OUT, // Gated crystal clock
   output logic BASE_CLK_OUT, // Base clock, half source
   output logic IRQ // Lock change interrupt
);
   // Synchronisers for asynchronous inputs
   logic [1:0] lock_sync_ff; // Lock two-stage
   logic [1:0] xclk_sync_ff; // Crystal two-stage
   logic [1:0] vclk_sync_ff; // VCO two-stage
   logic [1:0] wait_sync_ff; // Wait two-stage
   logic [1:0] stop_sync_ff; // Stop two-stage
   logic [1:0] ose_sync_ff; // Oscillator option two-stage
   logic [1:0] brk_sync_ff; // Break two-stage
   logic [1:0] bce_sync_ff; // Break clear two-stage
   logic lock_d_ff; // Previous synchronised lock
   logic xclk_d_ff; // Previous crystal level
   logic vclk_d_ff; // Previous VCO level
   // Register state
   logic [7:0] range_ff; // Range multiplier
   logic [3:0] ref_div_ff; // Reference divider
   logic loop_on_ff; // Loop enable
   logic base_sel_ff; // Base clock select
   logic irq_en_ff; // Interrupt enable
   logic flag_ff; // Lock change flag
   logic auto_ff; // Automatic bandwidth
   logic base_clk_ff; // Base clock divider output
   logic [31:0] nxt_prdata; // Read mux
   // Decoded strobes and states
   logic wr_acc, rd_acc; // Access phase strobes
   logic lock_s, stop_s, brk_s; // Synchronised levels
   logic lock_edge; // Lock transition pulse
   logic range_zero; // Range all zero
   logic rd_lc; // Loop control read
   logic clr_ok; // Read may clear flag
   logic osc_off; // Oscillator stopped
   logic xclk_rise, vclk_rise; // Source edges
   logic wait_s; // Wait level, observed only

   assign lock_s = lock_sync_ff[1];
   assign stop_s = stop_sync_ff[1];
   assign brk_s = brk_sync_ff[1];
   assign wait_s = wait_sync_ff[1];

   // Two flip-flops on every outside input except the APB bus
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         lock_sync_ff <= 2'h0;
         xclk_sync_ff <= 2'h0;
         vclk_sync_ff <= 2'h0;
         wait_sync_ff <= 2'h0;
         stop_sync_ff <= 2'h0;
         ose_sync_ff <= 2'h0;
         brk_sync_ff <= 2'h0;
         bce_sync_ff <= 2'h0;
      end else begin
         lock_sync_ff <= {lock_sync_ff[0], LOCK_IN};
         xclk_sync_ff <= {xclk_sync_ff[0], XTAL_CLK_IN};
         vclk_sync_ff <= {vclk_sync_ff[0], VCO_CLK_IN};
         wait_sync_ff <= {wait_sync_ff[0], WAIT_IN};
         stop_sync_ff <= {stop_sync_ff[0], STOP_IN};
         ose_sync_ff <= {ose_sync_ff[0], OSC_STOP_EN};
         brk_sync_ff <= {brk_sync_ff[0], BREAK_IN};
         bce_sync_ff <= {bce_sync_ff[0], BREAK_CLR_EN};
      end
   end

   // APB decode; zero wait states
   assign PREADY = 1'b1;
   assign wr_acc = PSEL & PENABLE & PWRITE;
   assign rd_acc = PSEL & PENABLE & ~PWRITE;
   assign PSLVERR = PSEL & PENABLE & (PADDR != plrd_pkg::ADDR_LOOP_CTRL)
      & (PADDR != plrd_pkg::ADDR_BW_CTRL) & (PADDR != plrd_pkg::ADDR_RANGE)
      & (PADDR != plrd_pkg::ADDR_REF_DIV) & (PADDR != plrd_pkg::ADDR_STATE);
   assign rd_lc = rd_acc & (PADDR == plrd_pkg::ADDR_LOOP_CTRL);
   assign clr_ok = ~brk_s | bce_sync_ff[1];
   assign range_zero = (range_ff == 8'h00);

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         lock_d_ff <= 1'b0;
      end else begin
         lock_d_ff <= lock_s;
      end
   end
   assign lock_edge = lock_s ^ lock_d_ff;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         range_ff <= plrd_pkg::RANGE_RST;
      end else if (wr_acc && PADDR == plrd_pkg::ADDR_RANGE && !loop_on_ff) begin
         range_ff <= PWDATA[7:0];
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ref_div_ff <= plrd_pkg::REF_DIV_RST;
      end else if (wr_acc && PADDR == plrd_pkg::ADDR_REF_DIV && !loop_on_ff) begin
         ref_div_ff <= PWDATA[3:0];
      end
   end

   // Loop enable; a write cannot clear it while base select set
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         loop_on_ff <= plrd_pkg::LOOP_ON_RST;
      end else if (range_zero) begin
         loop_on_ff <= 1'b0;
      end else if (stop_s) begin
         loop_on_ff <= 1'b0;
      end else if (wr_acc && PADDR == plrd_pkg::ADDR_LOOP_CTRL) begin
         loop_on_ff <= PWDATA[plrd_pkg::LC_LOOP_ON] | base_sel_ff;
      end
   end

   // Base clock select interlocks
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         base_sel_ff <= 1'b0;
      end else if (range_zero) begin
         base_sel_ff <= 1'b0;
      end else if (stop_s) begin
         base_sel_ff <= 1'b0;
      end else if (wr_acc && PADDR == plrd_pkg::ADDR_LOOP_CTRL) begin
         // lock not checked; needs loop on
         base_sel_ff <= PWDATA[plrd_pkg::LC_BASE_SEL] & loop_on_ff;
      end
   end

   // Interrupt enable and bandwidth mode; enable only writable in auto
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         irq_en_ff <= 1'b0;
         auto_ff <= 1'b0;
      end else begin
         if (wr_acc && PADDR == plrd_pkg::ADDR_LOOP_CTRL && auto_ff) begin
            irq_en_ff <= PWDATA[plrd_pkg::LC_IRQ_EN];
         end
         if (wr_acc && PADDR == plrd_pkg::ADDR_BW_CTRL) begin
            auto_ff <= PWDATA[plrd_pkg::BW_AUTO];
         end
      end
   end

   // Lock change flag; a set wins over a read clear
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         flag_ff <= 1'b0;
      end else if (!auto_ff) begin
         flag_ff <= 1'b0;
      end else if (lock_edge) begin
         flag_ff <= 1'b1;
      end else if (rd_lc && clr_ok) begin
         flag_ff <= 1'b0;
      end
   end

   // Read mux
   always_comb begin
      nxt_prdata = 32'h0000_0000;
      if (PADDR == plrd_pkg::ADDR_LOOP_CTRL) begin
         nxt_prdata[plrd_pkg::LC_IRQ_EN] = irq_en_ff & auto_ff;
         nxt_prdata[plrd_pkg::LC_FLAG] = flag_ff & auto_ff;
         nxt_prdata[plrd_pkg::LC_LOOP_ON] = loop_on_ff;
         nxt_prdata[plrd_pkg::LC_BASE_SEL] = base_sel_ff;
      end else if (PADDR == plrd_pkg::ADDR_BW_CTRL) begin
         nxt_prdata[plrd_pkg::BW_AUTO] = auto_ff;
         nxt_prdata[plrd_pkg::BW_LOCK] = lock_s & auto_ff;
      end else if (PADDR == plrd_pkg::ADDR_RANGE) begin
         nxt_prdata[7:0] = range_ff;
      end else if (PADDR == plrd_pkg::ADDR_REF_DIV) begin
         nxt_prdata[3:0] = ref_div_ff;
      end else if (PADDR == plrd_pkg::ADDR_STATE) begin
         nxt_prdata[plrd_pkg::ST_WAIT] = wait_s;
         nxt_prdata[plrd_pkg::ST_STOP] = stop_s;
         nxt_prdata[plrd_pkg::ST_OSC_STOP_EN] = ose_sync_ff[1];
         nxt_prdata[plrd_pkg::ST_BREAK] = brk_s;
         nxt_prdata[plrd_pkg::ST_BREAK_CLR_EN] = bce_sync_ff[1];
      end
   end
   // Read data combinational in the access phase of a zero-wait slave
   assign PRDATA = rd_acc ? nxt_prdata : 32'h0000_0000;

   // Source edge detection on sampled clocks
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         xclk_d_ff <= 1'b0;
         vclk_d_ff <= 1'b0;
      end else begin
         xclk_d_ff <= xclk_sync_ff[1];
         vclk_d_ff <= vclk_sync_ff[1];
      end
   end
   assign xclk_rise = xclk_sync_ff[1] & ~xclk_d_ff;
   assign vclk_rise = vclk_sync_ff[1] & ~vclk_d_ff;
   // oscillator stops only without the option
   assign osc_off = stop_s & ~ose_sync_ff[1];

   // toggle on each rising edge of the selected source
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         base_clk_ff <= 1'b0;
      end else if (osc_off) begin
         base_clk_ff <= 1'b0;
      end else if (base_sel_ff ? vclk_rise : xclk_rise) begin
         base_clk_ff <= ~base_clk_ff;
      end
   end

   // Outputs; wait has no effect on any of them
   assign LOOP_ENABLE = loop_on_ff;
   assign OSC_ENABLE = ~osc_off;
   assign RANGE_OUT = range_ff;
   assign REF_DIV_OUT = (ref_div_ff == 4'h0) ? 4'h1 : ref_div_ff;
   assign XTAL_CLK_OUT = xclk_sync_ff[1] & ~osc_off;
   assign BASE_CLK_OUT = base_clk_ff;
   assign IRQ = flag_ff & irq_en_ff & auto_ff & ~osc_off;

   // Lock change must set the flag next cycle in auto mode
   property p_flag_set;
      @(posedge REF_CLK) disable iff (!RST_N)
         auto_ff && lock_edge |=> flag_ff || !auto_ff;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set");

   property p_range_hold;
      @(posedge REF_CLK) disable iff (!RST_N)
         loop_on_ff |=> $stable(range_ff);
   endproperty
   a_range_hold: assert property (p_range_hold) else $error("range changed");

   property p_div_hold;
      @(posedge REF_CLK) disable iff (!RST_N)
         loop_on_ff |=> $stable(ref_div_ff);
   endproperty
   a_div_hold: assert property (p_div_hold) else $error("divider changed");

   property p_zero_range;
      @(posedge REF_CLK) disable iff (!RST_N)
         range_zero |=> !base_sel_ff && !loop_on_ff;
   endproperty
   a_zero_range: assert property (p_zero_range) else $error("zero range");

   property p_irq_gate;
      @(posedge REF_CLK) disable iff (!RST_N)
         IRQ |-> irq_en_ff && flag_ff && auto_ff;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq ungated");

   property p_manual_flag;
      @(posedge REF_CLK) disable iff (!RST_N)
         !auto_ff |=> !flag_ff;
   endproperty
   a_manual_flag: assert property (p_manual_flag) else $error("manual flag");

   property p_break_keep;
      @(posedge REF_CLK) disable iff (!RST_N)
         flag_ff && auto_ff && brk_s && !bce_sync_ff[1] && rd_lc |=> flag_ff;
   endproperty
   a_break_keep: assert property (p_break_keep) else $error("flag lost");

   property p_read_clear;
      @(posedge REF_CLK) disable iff (!RST_N)
         rd_lc && clr_ok && !lock_edge && auto_ff ##1 auto_ff |-> !flag_ff;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("no clear");

   property p_stop_sel;
      @(posedge REF_CLK) disable iff (!RST_N)
         stop_s |=> !base_sel_ff && !loop_on_ff;
   endproperty
   a_stop_sel: assert property (p_stop_sel) else $error("stop select");

   property p_stop_low;
      @(posedge REF_CLK) disable iff (!RST_N)
         osc_off |-> !XTAL_CLK_OUT && !IRQ ##1 (!BASE_CLK_OUT || !osc_off);
   endproperty
   a_stop_low: assert property (p_stop_low) else $error("stop outputs");
endmodule
`default_nettype wire

// [logic/plrd_pkg.sv]
package plrd_pkg;
   // Register byte addresses on the APB
   localparam logic [7:0] ADDR_LOOP_CTRL = 8'h00;
   localparam logic [7:0] ADDR_BW_CTRL = 8'h04;
   localparam logic [7:0] ADDR_RANGE = 8'h08;
   localparam logic [7:0] ADDR_REF_DIV = 8'h0C;
   localparam logic [7:0] ADDR_STATE = 8'h10;
   // Loop control register fields
   localparam int LC_IRQ_EN = 7;
   localparam int LC_FLAG = 6;
   localparam int LC_LOOP_ON = 5;
   localparam int LC_BASE_SEL = 4;
   // Bandwidth control register fields
   localparam int BW_AUTO = 7;
   localparam int BW_LOCK = 6;
   // Mode input register fields
   localparam int ST_WAIT = 0;
   localparam int ST_STOP = 1;
   localparam int ST_OSC_STOP_EN = 2;
   localparam int ST_BREAK = 3;
   localparam int ST_BREAK_CLR_EN = 4;
   // Reset values
   localparam logic [7:0] RANGE_RST = 8'h40;
   localparam logic [3:0] REF_DIV_RST = 4'h1;
   localparam logic LOOP_ON_RST = 1'b1;
endpackage

// [test/plrd_ctrl_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module plrd_ctrl_tb;
   logic ref_clk = 1'b0; // System clock, 4 ns period
   logic rst_n = 1'b0; // Reset, active low
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
   logic [7:0] paddr = 8'h00; // APB address
   logic [31:0] pwdata = 32'h0; // APB write data
   logic lock_in = 1'b0, xtal = 1'b0, vco = 1'b0; // Analog side levels
   logic wait_in = 1'b0, stop_in = 1'b0, osc_opt = 1'b0; // Low-power states
   logic brk = 1'b0, brk_clr = 1'b0; // Debug break controls
   wire logic [31:0] prdata; // APB read data
   wire logic pready, pslverr, loop_en, osc_en, xtal_out, base_clk, irq; // Outputs
   wire logic [7:0] range_out; // Range to VCO
   wire logic [3:0] ref_div_out; // Effective divider
   int n_fail = 0; // Mismatches
   int check_count = 0; // Comparisons
   int cyc = 0; // Cycle count for the hang guard
   integer seed = 32'hC6BF1E79; // Fixed seed for repeatable runs
   logic [31:0] r, v; // Read data and random value
   logic e; // Slave error seen
   always #2 ref_clk = ~ref_clk;
   plrd_ctrl i_plrd_ctrl (.REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .LOCK_IN(lock_in), .XTAL_CLK_IN(xtal), .VCO_CLK_IN(vco),
      .WAIT_IN(wait_in), .STOP_IN(stop_in), .OSC_STOP_EN(osc_opt), .BREAK_IN(brk),
      .BREAK_CLR_EN(brk_clr), .LOOP_ENABLE(loop_en), .OSC_ENABLE(osc_en),
      .RANGE_OUT(range_out), .REF_DIV_OUT(ref_div_out), .XTAL_CLK_OUT(xtal_out),
      .BASE_CLK_OUT(base_clk), .IRQ(irq));
   // Verdict and end of run
   task automatic complete_run();
      if (n_fail == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Compare one value, four-state exact
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Hang guard: the full sequence needs well under 4000 cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         complete_run();
      end
   end
   // One APB transfer; entered and left just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   // Divider zero behaves as one
   function automatic logic [3:0] eff_div(input logic [3:0] f);
      return (f == 4'h0) ? 4'h1 : f;
   endfunction
   // Flip the lock level and let synchroniser and flag settle
   task automatic lock_flip();
      lock_in <= ~lock_in;
      repeat (6) @(posedge ref_clk);
   endtask
   // Let a level input pass its two-stage synchroniser
   task automatic settle();
      repeat (5) @(posedge ref_clk);
   endtask
   // Toggle one source for eight periods and count base clock changes
   task automatic src_run(input logic use_vco, input int exp);
      int ch;
      logic prev;
      ch = 0;
      prev = base_clk;
      for (int i = 0; i < 136; i++) begin
         if (i < 128 && use_vco) vco <= (i % 16) < 8;
         if (i < 128 && !use_vco) xtal <= (i % 16) < 8;
         @(posedge ref_clk);
         if (base_clk !== prev) ch++;
         prev = base_clk;
      end
      chk("base clock changes", ch, exp);
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      settle();
      apb(1'b0, plrd_pkg::ADDR_RANGE, 32'h0);
      chk("range reset", r, 32'h40); // reset value
      chk("range out", range_out, 32'h40); // pin value
      apb(1'b0, plrd_pkg::ADDR_REF_DIV, 32'h0);
      chk("divider reset", r, 32'h01); // reset value
      chk("divider out", ref_div_out, 32'h1); // pin value
      apb(1'b0, plrd_pkg::ADDR_LOOP_CTRL, 32'h0);
      chk("loop ctrl reset", r, 32'h20);
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped error", e, 32'h1);
      for (int i = 0; i < 4; i++) begin
         v = $random(seed);
         apb(1'b1, plrd_pkg::ADDR_RANGE, v);
         apb(1'b1, plrd_pkg::ADDR_REF_DIV, v);
         apb(1'b0, plrd_pkg::ADDR_RANGE, 32'h0);
         chk("range locked", r, 32'h40); // write ignored
         apb(1'b0, plrd_pkg::ADDR_REF_DIV, 32'h0);
         chk("divider locked", r, 32'h01); // write ignored
      end
      apb(1'b1, plrd_pkg::ADDR_LOOP_CTRL, 32'h0);
      for (int i = 0; i < 8; i++) begin
         v = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFFFFF0 : $random(seed);
         if (v[7:0] == 8'h00) v[0] = 1'b1;
         apb(1'b1, plrd_pkg::ADDR_RANGE, v);
         apb(1'b0, plrd_pkg::ADDR_RANGE, 32'h0);
         chk("range written", r, {24'h0, v[7:0]}); // accepted while off
         if (i == 0) v = 32'h0;
         if (i == 1) v = 32'hFFFFFFF0;
         apb(1'b1, plrd_pkg::ADDR_REF_DIV, v);
         apb(1'b0, plrd_pkg::ADDR_REF_DIV, 32'h0);
         chk("divider read", r, {28'h0, v[3:0]}); // upper nibble zero
         chk("divider out", ref_div_out, eff_div(v[3:0])); // zero as one
      end
      apb(1'b1, plrd_pkg::ADDR_RANGE, 32'h0);
      apb(1'b1, plrd_pkg::ADDR_LOOP_CTRL, 32'h30);
      apb(1'b0, plrd_pkg::ADDR_LOOP_CTRL, 32'h0);
      chk("zero range ctrl", r & 32'h30, 32'h0); // loop off, select refused
      chk("zero range loop", loop_en, 32'h0); // loop held off
      apb(1'b1, plrd_pkg::ADDR_RANGE, 32'h40);
      apb(1'b1, plrd_pkg::ADDR_LOOP_CTRL, 32'h20);
      apb(1'b1, plrd_pkg::ADDR_LOOP_CTRL, 32'h30);
      apb(1'b0, plrd_pkg::ADDR_LOOP_CTRL, 32'h0);
      chk("select unlocked", r & 32'h30, 32'h30); // select taken, lock low
      src_run(1'b1, 8); // VCO source halved
      src_run(1'b0, 0); // crystal not selected
      wait_in <= 1'b1;
      settle();
      apb(1'b0, plrd_pkg::ADDR_LOOP_CTRL, 32'h0);
      chk("wait ctrl", r, 32'h30); // state unchanged
      chk("wait loop", loop_en, 32'h1); // loop kept
      apb(1'b0, plrd_pkg::ADDR_STATE, 32'h0);
      chk("wait state", r, 32'h01); // wait seen, nothing else
      src_run(1'b1, 8); // base clock still running
      wait_in <= 1'b0;
      apb(1'b1, plrd_pkg::ADDR_BW_CTRL, 32'h80);
      apb(1'b1, plrd_pkg::ADDR_LOOP_CTRL, 32'hB0);
      lock_flip();
      chk("irq on change", irq, 32'h1); // enabled request
      apb(1'b0, plrd_pkg::ADDR_BW_CTRL, 32'h0);
      chk("lock readback", r, 32'hC0); // auto mode shows lock
      apb(1'b0, plrd_pkg::ADDR_LOOP_CTRL, 32'h0);
      chk("flag set", r[6], 32'h1); // flag on change
      apb(1'b0, plrd_pkg::ADDR_LOOP_CTRL, 32'h0);
      chk("flag read clear", r[6], 32'h0); // read clears
      chk("irq cleared", irq, 32'h0); // request drops
      apb(1'b1, plrd_pkg::ADDR_LOOP_CTRL, 32'h30);
      lock_flip();
      chk("irq masked", irq, 32'h0); // enable low
      apb(1'b0, plrd_pkg::ADDR_LOOP_CTRL, 32'h0);
      chk("flag masked", r[6], 32'h1); // flag regardless
      brk <= 1'b1;
      settle();
      lock_flip();
      apb(1'b0, plrd_pkg::ADDR_LOOP_CTRL, 32'h0);
      apb(1'b1, plrd_pkg::ADDR_LOOP_CTRL, 32'h30);
      apb(1'b0, plrd_pkg::ADDR_LOOP_CTRL, 32'h0);
      chk("flag protected", r[6], 32'h1); // read and write keep flag
      brk_clr <= 1'b1;
      settle();
      apb(1'b0, plrd_pkg::ADDR_LOOP_CTRL, 32'h0);
      brk <= 1'b0;
      settle();
      apb(1'b0, plrd_pkg::ADDR_LOOP_CTRL, 32'h0);
      chk("flag stays clear", r[6], 32'h0); // cleared in break
      brk_clr <= 1'b0;
      apb(1'b1, plrd_pkg::ADDR_BW_CTRL, 32'h0);
      lock_flip();
      apb(1'b0, plrd_pkg::ADDR_LOOP_CTRL, 32'h0);
      chk("manual flag", r[6], 32'h0); // flag reads zero
      chk("manual irq", irq, 32'h0); // no request
      apb(1'b1, plrd_pkg::ADDR_BW_CTRL, 32'h80);
      apb(1'b1, plrd_pkg::ADDR_LOOP_CTRL, 32'hB0);
      stop_in <= 1'b1;
      xtal <= 1'b1;
      settle();
      lock_flip();
      chk("stop osc", osc_en, 32'h0); // oscillator off
      chk("stop loop", loop_en, 32'h0); // loop off
      chk("stop xtal", xtal_out, 32'h0); // crystal held low
      chk("stop base", base_clk, 32'h0); // base held low
      chk("stop irq", irq, 32'h0); // interrupt held low
      src_run(1'b0, 0); // no base clock in stop
      stop_in <= 1'b0;
      settle();
      apb(1'b0, plrd_pkg::ADDR_LOOP_CTRL, 32'h0);
      chk("stop select", r & 32'h10, 32'h0); // select cleared
      src_run(1'b0, 8); // crystal drives after stop
      // Loop back on first, so that the option case really turns it off
      apb(1'b1, plrd_pkg::ADDR_LOOP_CTRL, 32'h20);
      chk("opt loop before", loop_en, 32'h1); // loop on before stop
      osc_opt <= 1'b1;
      stop_in <= 1'b1;
      xtal <= 1'b1;
      settle();
      chk("opt osc", osc_en, 32'h1); // oscillator kept
      chk("opt loop", loop_en, 32'h0); // loop off
      chk("opt xtal", xtal_out, 32'h1); // crystal still passes
      apb(1'b0, plrd_pkg::ADDR_STATE, 32'h0);
      chk("opt state", r, 32'h06); // stop with option seen
      stop_in <= 1'b0;
      osc_opt <= 1'b0;
      xtal <= 1'b0;
      settle();
      complete_run();
   end
endmodule
`default_nettype wire
